/* File: hdl/i2c_dma_defines.svh */
// constants shared by the i2c sram dma slave
`ifndef I2C_DMA_DEFINES_SVH
`define I2C_DMA_DEFINES_SVH

// own 7-bit slave address; the value is arbitrary
`define OWN_SLAVE_ADDR 7'h2A
`define BYTE_BITS 4'h8
`define BIT_CNT_ZERO 4'h0
`define IDLE_TX_BYTE 8'hFF
`define WIN_BASE_W 3
`define PTR_W 8
`define SRAM_ADDR_W 11
`define FIFO_WIDTH 8
`define FIFO_DEPTH 2
`define PTR_RESET 8'h00

`endif

/* File: hdl/i2c_dma_pkg.sv */
// types for the i2c sram dma slave
package i2c_dma_pkg;

  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_HOLD,
    S_ADDR_ACK,
    S_WR,
    S_WR_ACK,
    S_TXWAIT,
    S_RD,
    S_RD_ACK
  } slvState_t;

endpackage : i2c_dma_pkg

/* File: hdl/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rstSync_b,
  input wire logic pinIn,
  output logic level
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;
  logic level_r;
  logic level_nxt;

  // a change is taken only once the two settled stages agree
  always_comb begin
    level_nxt = (stage2_r == stage3_r) ? stage3_r : level_r;
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      stage1_r <= INIT;
      stage2_r <= INIT;
      stage3_r <= INIT;
      level_r <= INIT;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;

endmodule : pin_sync
`default_nettype wire

/* File: hdl/byte_fifo2.sv */
// small transmit buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
`include "i2c_dma_defines.svh"
module byte_fifo2 #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstSync_b,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [IW-1:0] wrIdx_r;
  logic [IW-1:0] wrIdx_nxt;
  logic [IW-1:0] rdIdx_r;
  logic [IW-1:0] rdIdx_nxt;
  logic [IW:0] count_r;
  logic [IW:0] count_nxt;
  logic push;
  logic pop;

  function automatic logic [IW-1:0] nextIdx(input logic [IW-1:0] idx);
    nextIdx = (idx == IW'(DEPTH - 1)) ? '0 : idx + IW'(1);
  endfunction : nextIdx

  always_comb begin
    inReady = (count_r != (IW+1)'(DEPTH));
    outValid = (count_r != '0);
    outData = mem_r[rdIdx_r];
    push = inValid && inReady;
    pop = outValid && outReady;
    mem_nxt = mem_r;
    wrIdx_nxt = wrIdx_r;
    rdIdx_nxt = rdIdx_r;
    count_nxt = count_r + (IW+1)'(push) - (IW+1)'(pop);
    if (push) begin
      mem_nxt[wrIdx_r] = inData;
      wrIdx_nxt = nextIdx(wrIdx_r);
    end
    if (pop) begin
      rdIdx_nxt = nextIdx(rdIdx_r);
    end
    // flush drops residual words left from an earlier read
    if (flush) begin
      wrIdx_nxt = '0;
      rdIdx_nxt = '0;
      count_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wrIdx_r <= '0;
      rdIdx_r <= '0;
      count_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wrIdx_r <= wrIdx_nxt;
      rdIdx_r <= rdIdx_nxt;
      count_r <= count_nxt;
    end
  end

endmodule : byte_fifo2
`default_nettype wire

/* File: hdl/i2c_slave_sram_dma.sv */
// i2c slave with ack polling, stretching and byte dma into sram
`timescale 1ns/100ps
`default_nettype none
`include "i2c_dma_defines.svh"
module i2c_slave_sram_dma
  import i2c_dma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOeB,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeB,
  input wire logic dmaEn,
  input wire logic [`WIN_BASE_W-1:0] winBase,
  input wire logic eepromMode,
  input wire logic stretchDis,
  input wire logic devBusy,
  input wire logic coreStopped,
  input wire logic fifoFlush,
  output logic [`SRAM_ADDR_W-1:0] sramAddr,
  output logic [7:0] sramWdata,
  output logic sramWe,
  output logic sramRe,
  input wire logic [7:0] sramRdata,
  output logic wakeReq,
  output logic [`PTR_W-1:0] ptrValue
);

  // ********************************************************************
  // reset release and pin conditioning
  // ********************************************************************
  logic rstMeta_r;
  logic rstSync_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  logic sclLvl;
  logic sdaLvl;

  pin_sync u_sclSync (
    .clk_sys(clk_sys),
    .rstSync_b(rstSync_r),
    .pinIn(sclIn),
    .level(sclLvl)
  );

  pin_sync u_sdaSync (
    .clk_sys(clk_sys),
    .rstSync_b(rstSync_r),
    .pinIn(sdaIn),
    .level(sdaLvl)
  );

  // ********************************************************************
  // transmit fifo
  // ********************************************************************
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic [7:0] fifoData;

  byte_fifo2 u_txFifo (
    .clk_sys(clk_sys),
    .rstSync_b(rstSync_r),
    .flush(fifoFlush),
    .inValid(sramRe),
    .inReady(fifoInReady),
    .inData(sramRdata),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  // ********************************************************************
  // protocol and dma state
  // ********************************************************************
  slvState_t st_r, st_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] rxShift_r, rxShift_nxt;
  logic [7:0] txShift_r, txShift_nxt;
  logic rw_r, rw_nxt;
  logic ackSeen_r, ackSeen_nxt;
  logic initPend_r, initPend_nxt;
  logic ptrLoad_r, ptrLoad_nxt;
  logic [`PTR_W-1:0] ptr_r, ptr_nxt;
  logic raArmed_r, raArmed_nxt;
  logic eePend_r, eePend_nxt;
  logic [`SRAM_ADDR_W-1:0] sramAddr_r, sramAddr_nxt;
  logic [7:0] sramWdata_r, sramWdata_nxt;
  logic sramWe_r, sramWe_nxt;
  logic sramRe_r, sramRe_nxt;
  logic sdaOeB_r, sdaOeB_nxt;
  logic sclOeB_r, sclOeB_nxt;
  logic wakeReq_r, wakeReq_nxt;
  logic sclPrev_r;
  logic sdaPrev_r;
  logic lowDrive_r;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic ready;
  logic addrMatch;
  logic takeAddr;
  logic loadTx;
  logic wrByte;

  function automatic logic [`SRAM_ADDR_W-1:0] winAddr(
    input logic [`WIN_BASE_W-1:0] base,
    input logic [`PTR_W-1:0] ptr
  );
    winAddr = {base, ptr};
  endfunction : winAddr

  always_comb begin
    sclRise = sclLvl && !sclPrev_r;
    sclFall = !sclLvl && sclPrev_r;
    startCond = sclLvl && sclPrev_r && sdaPrev_r && !sdaLvl;
    stopCond = sclLvl && sclPrev_r && !sdaPrev_r && sdaLvl;
    ready = dmaEn && !devBusy;
    addrMatch = (rxShift_r[7:1] == `OWN_SLAVE_ADDR);
    takeAddr = ((st_r == S_ADDR) && sclFall && (bitCnt_r == `BYTE_BITS)
                && addrMatch && ready) || ((st_r == S_HOLD) && ready);
    wrByte = (st_r == S_WR) && sclFall && (bitCnt_r == `BYTE_BITS)
             && !devBusy;
    loadTx = 1'b0;
    fifoPop = 1'b0;
    st_nxt = st_r;
    bitCnt_nxt = bitCnt_r;
    rxShift_nxt = rxShift_r;
    txShift_nxt = txShift_r;
    rw_nxt = rw_r;
    ackSeen_nxt = ackSeen_r;
    initPend_nxt = initPend_r;
    ptrLoad_nxt = ptrLoad_r;
    ptr_nxt = ptr_r;
    raArmed_nxt = raArmed_r;
    eePend_nxt = eePend_r;
    sramAddr_nxt = sramAddr_r;
    sramWdata_nxt = sramWdata_r;
    sramWe_nxt = 1'b0;
    sramRe_nxt = 1'b0;
    sdaOeB_nxt = sdaOeB_r;
    sclOeB_nxt = sclOeB_r;
    wakeReq_nxt = 1'b0;
    unique case (st_r)
      S_IDLE: begin
      end
      S_ADDR: begin
        if (sclRise) begin
          rxShift_nxt = {rxShift_r[6:0], sdaLvl};
          bitCnt_nxt = bitCnt_r + 4'h1;
        end else if (sclFall && bitCnt_r == `BYTE_BITS) begin
          if (addrMatch) begin
            wakeReq_nxt = coreStopped;
            if (!ready && stretchDis) begin
              st_nxt = S_IDLE;
            end else if (!ready) begin
              st_nxt = S_HOLD;
              sclOeB_nxt = 1'b0;
            end
          end else begin
            st_nxt = S_IDLE;
          end
        end
      end
      S_HOLD: begin
      end
      S_ADDR_ACK: begin
        if (sclFall) begin
          sdaOeB_nxt = 1'b1;
          bitCnt_nxt = `BIT_CNT_ZERO;
          loadTx = rw_r;
          st_nxt = rw_r ? S_RD : S_WR;
        end
      end
      S_WR: begin
        if (sclRise) begin
          rxShift_nxt = {rxShift_r[6:0], sdaLvl};
          bitCnt_nxt = bitCnt_r + 4'h1;
        end else if (sclFall && bitCnt_r == `BYTE_BITS) begin
          if (devBusy) begin
            // sda stays released, so the master sees a nack
            st_nxt = S_IDLE;
          end else begin
            sdaOeB_nxt = 1'b0;
            st_nxt = S_WR_ACK;
            if (ptrLoad_r) begin
              ptr_nxt = rxShift_r;
              ptrLoad_nxt = 1'b0;
            end else begin
              sramWe_nxt = 1'b1;
              sramWdata_nxt = rxShift_r;
              sramAddr_nxt = winAddr(winBase, ptr_r);
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
      end
      S_WR_ACK: begin
        if (sclFall) begin
          sdaOeB_nxt = 1'b1;
          bitCnt_nxt = `BIT_CNT_ZERO;
          st_nxt = S_WR;
        end
      end
      S_TXWAIT: begin
        loadTx = fifoOutValid;
      end
      S_RD: begin
        if (sclRise) begin
          bitCnt_nxt = bitCnt_r + 4'h1;
        end else if (sclFall && bitCnt_r == `BYTE_BITS) begin
          sdaOeB_nxt = 1'b1;
          st_nxt = S_RD_ACK;
        end else if (sclFall) begin
          txShift_nxt = {txShift_r[6:0], 1'b1};
          sdaOeB_nxt = txShift_r[6];
        end
      end
      S_RD_ACK: begin
        if (sclRise) begin
          ackSeen_nxt = !sdaLvl;
          if (eepromMode && !sdaLvl) begin
            eePend_nxt = 1'b1;
          end
        end else if (sclFall) begin
          loadTx = ackSeen_r;
          // a nack ends the read; in eeprom mode no further fetch follows, while read-ahead keeps filling the fifo
          if (!ackSeen_r) begin
            st_nxt = S_IDLE;
          end
        end
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
    if (loadTx) begin
      bitCnt_nxt = `BIT_CNT_ZERO;
      if (fifoOutValid) begin
        fifoPop = 1'b1;
        txShift_nxt = fifoData;
        sdaOeB_nxt = fifoData[7];
        sclOeB_nxt = 1'b1;
        st_nxt = S_RD;
      end else if (!stretchDis) begin
        sclOeB_nxt = 1'b0;
        st_nxt = S_TXWAIT;
      end else begin
        // no data and no stretch: the master reads all ones
        txShift_nxt = `IDLE_TX_BYTE;
        sdaOeB_nxt = 1'b1;
        st_nxt = S_RD;
      end
    end
    if (takeAddr) begin
      sdaOeB_nxt = 1'b0;
      sclOeB_nxt = 1'b1;
      st_nxt = S_ADDR_ACK;
      rw_nxt = rxShift_r[0];
      if (rxShift_r[0] && eepromMode) begin
        eePend_nxt = 1'b1;
      end else if (rxShift_r[0]) begin
        raArmed_nxt = 1'b1;
      end else begin
        raArmed_nxt = 1'b0;
      end
    end
    // one fetch in flight keeps the fifo space check exact
    if (!wrByte && !sramRe_r && fifoInReady
        && ((raArmed_r && !eepromMode) || eePend_r)) begin
      sramRe_nxt = 1'b1;
      sramAddr_nxt = winAddr(winBase, ptr_r);
      ptr_nxt = ptr_r + 8'h01;
      eePend_nxt = 1'b0;
    end
    if (startCond) begin
      st_nxt = S_ADDR;
      bitCnt_nxt = `BIT_CNT_ZERO;
      sdaOeB_nxt = 1'b1;
      sclOeB_nxt = 1'b1;
      ptrLoad_nxt = initPend_r;
      initPend_nxt = 1'b0;
    end
    // fifo is left as is on stop; residual words serve the next read
    if (stopCond) begin
      st_nxt = S_IDLE;
      sdaOeB_nxt = 1'b1;
      sclOeB_nxt = 1'b1;
      initPend_nxt = 1'b1;
      ptrLoad_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      st_r <= S_IDLE;
      bitCnt_r <= `BIT_CNT_ZERO;
      rxShift_r <= 8'h00;
      txShift_r <= 8'h00;
      rw_r <= 1'b0;
      ackSeen_r <= 1'b0;
      initPend_r <= 1'b1;
      ptrLoad_r <= 1'b0;
      ptr_r <= `PTR_RESET;
      raArmed_r <= 1'b0;
      eePend_r <= 1'b0;
      sramAddr_r <= 11'h000;
      sramWdata_r <= 8'h00;
      sramWe_r <= 1'b0;
      sramRe_r <= 1'b0;
      sdaOeB_r <= 1'b1;
      sclOeB_r <= 1'b1;
      wakeReq_r <= 1'b0;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      lowDrive_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bitCnt_r <= bitCnt_nxt;
      rxShift_r <= rxShift_nxt;
      txShift_r <= txShift_nxt;
      rw_r <= rw_nxt;
      ackSeen_r <= ackSeen_nxt;
      initPend_r <= initPend_nxt;
      ptrLoad_r <= ptrLoad_nxt;
      ptr_r <= ptr_nxt;
      raArmed_r <= raArmed_nxt;
      eePend_r <= eePend_nxt;
      sramAddr_r <= sramAddr_nxt;
      sramWdata_r <= sramWdata_nxt;
      sramWe_r <= sramWe_nxt;
      sramRe_r <= sramRe_nxt;
      sdaOeB_r <= sdaOeB_nxt;
      sclOeB_r <= sclOeB_nxt;
      wakeReq_r <= wakeReq_nxt;
      sclPrev_r <= sclLvl;
      sdaPrev_r <= sdaLvl;
      lowDrive_r <= 1'b0;
    end
  end

  assign sclOut = lowDrive_r;
  assign sdaOut = lowDrive_r;
  assign sclOeB = sclOeB_r;
  assign sdaOeB = sdaOeB_r;
  assign sramAddr = sramAddr_r;
  assign sramWdata = sramWdata_r;
  assign sramWe = sramWe_r;
  assign sramRe = sramRe_r;
  assign wakeReq = wakeReq_r;
  assign ptrValue = ptr_r;

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSync_r);

  sequence s_addrTaken;
    takeAddr && !startCond && !stopCond;
  endsequence

  a_ack_low: assert property (s_addrTaken |=> !sdaOeB_r [*2])
    else $error("address ack does not hold sda low");
  a_idle_release: assert property (st_r == S_IDLE |-> sdaOeB_r)
    else $error("sda driven while idle");
  a_busy_nack: assert property ((st_r == S_WR) && sclFall
      && (bitCnt_r == 4'h8) && devBusy && !startCond && !stopCond
      |=> sdaOeB_r && (st_r == S_IDLE) && !sramWe_r)
    else $error("busy data byte was not refused");
  a_window_addr: assert property (sramRe_r || sramWe_r
      |-> sramAddr_r[10:8] == $past(winBase))
    else $error("sram access outside selected window");
  a_one_fetch: assert property (sramRe_r |=> !sramRe_r)
    else $error("two fetches back to back");
  a_ptr_load: assert property (wrByte && ptrLoad_r && !startCond
      && !stopCond |=> !sramWe_r && ptr_r == $past(rxShift_r))
    else $error("first write byte not loaded into pointer");
  a_ptr_step: assert property (sramWe_r
      |-> ptr_r == sramAddr_r[7:0] + 8'h01)
    else $error("pointer did not advance after write");
  a_ee_nack: assert property (eepromMode && (st_r == S_RD_ACK)
      && sclRise && sdaLvl && !eePend_r
      |=> !eePend_r ##1 !sramRe_r)
    else $error("fetch started after master nack");
  a_wr_in_ack: assert property ($rose(sramWe_r)
      |-> st_r == S_WR_ACK && !sdaOeB_r)
    else $error("sram write outside the ack bit");
  a_stretch_hold: assert property (st_r == S_HOLD |-> !sclOeB_r)
    else $error("scl not held while waiting");
  a_wake_req: assert property ((st_r == S_ADDR) && sclFall
      && (bitCnt_r == 4'h8) && addrMatch && coreStopped
      && !startCond && !stopCond |=> wakeReq_r)
    else $error("address match did not raise wake");

endmodule : i2c_slave_sram_dma
`default_nettype wire

/* File: test/i2c_master_model.sv */
// i2c bus master model driving open-drain scl and sda
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model #(
  parameter int Q = 10
) (
  input wire logic clk_sys,
  input wire logic sclWire,
  input wire logic sdaWire,
  output logic sclRel,
  output logic sdaRel
);
  initial begin
    sclRel = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic q;
    repeat (Q) @(negedge clk_sys);
  endtask : q
  // the slave may stretch, so wait on the wire and not on our own drive
  task automatic sclUp;
    int n;
    sclRel = 1'b1;
    n = 0;
    while (sclWire !== 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : sclUp
  // serves as both initial and repeated start
  task automatic start;
    sdaRel = 1'b1;
    q();
    sclUp();
    q();
    sdaRel = 1'b0;
    q();
    sclRel = 1'b0;
    q();
  endtask : start
  task automatic stop;
    sdaRel = 1'b0;
    q();
    sclUp();
    q();
    sdaRel = 1'b1;
    q();
  endtask : stop
  // a bit reads high if sda is high at any sample in the scl high time
  task automatic bitXfer(input logic b, output logic r);
    sdaRel = b;
    q();
    sclUp();
    r = sdaWire;
    q();
    r = r | sdaWire;
    sclRel = 1'b0;
    q();
  endtask : bitXfer
  task automatic byteXfer(input logic [7:0] tx, input logic ackIn,
    output logic [7:0] rx, output logic ackOut);
    for (int i = 7; i >= 0; i--) bitXfer(tx[i], rx[i]);
    bitXfer(ackIn, ackOut);
  endtask : byteXfer
endmodule : i2c_master_model
`default_nettype wire

/* File: test/i2c_slave_sram_dma_tb_top.sv */
// self-checking bench for the i2c sram dma slave
`timescale 1ns/100ps
`default_nettype none
`include "i2c_dma_defines.svh"
module i2c_slave_sram_dma_tb_top;
  logic clk_sys, rst_b, sclRel, sdaRel, sclW, sdaW, sclOut, sclOeB, sdaOut;
  logic sdaOeB, dmaEn, eepromMode, stretchDis, devBusy, coreStopped;
  logic fifoFlush, sramWe, sramRe, wakeReq, ack, stretched;
  logic [2:0] winBase;
  logic [10:0] sramAddr;
  logic [7:0] sramWdata, sramRdata, rx, ptrValue;
  logic [7:0] mem [0:2047];
  int miscompares, tests_run, reads, writes, wakes;
  localparam logic [7:0] AW = {`OWN_SLAVE_ADDR, 1'b0};
  localparam logic [7:0] AR = {`OWN_SLAVE_ADDR, 1'b1};
  // pulled-up wires: low if anyone pulls
  assign sclW = sclRel & (sclOeB | sclOut);
  assign sdaW = sdaRel & (sdaOeB | sdaOut);
  i2c_slave_sram_dma i2c_slave_sram_dma_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .sclIn(sclW), .sclOut(sclOut), .sclOeB(sclOeB), .sdaIn(sdaW),
    .sdaOut(sdaOut), .sdaOeB(sdaOeB), .dmaEn(dmaEn), .winBase(winBase),
    .eepromMode(eepromMode), .stretchDis(stretchDis), .devBusy(devBusy),
    .coreStopped(coreStopped), .fifoFlush(fifoFlush), .sramAddr(sramAddr),
    .sramWdata(sramWdata), .sramWe(sramWe), .sramRe(sramRe),
    .sramRdata(sramRdata), .wakeReq(wakeReq), .ptrValue(ptrValue));
  i2c_master_model i2c_master_model_i (.clk_sys(clk_sys), .sclWire(sclW),
    .sdaWire(sdaW), .sclRel(sclRel), .sdaRel(sdaRel));
  // sram: read data stands while the strobe is high, scrambled otherwise
  assign sramRdata = sramRe ? mem[sramAddr] : ~mem[sramAddr];
  always @(posedge clk_sys) begin
    if (sramWe) begin
      mem[sramAddr] <= sramWdata;
      writes++;
    end
    if (sramRe) begin
      reads++;
    end
    if (!sclOeB) stretched <= 1'b1;
    if (wakeReq) wakes++;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string n, input logic [10:0] e,
    input logic [10:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tx(input logic [7:0] d, input logic e, input string n);
    i2c_master_model_i.byteXfer(d, 1'b1, rx, ack);
    chk(n, {10'h000, e}, {10'h000, ack});
  endtask : tx
  task automatic rd(input logic a, input logic [7:0] e);
    i2c_master_model_i.byteXfer(8'hFF, a, rx, ack);
    chk("read data", {3'h0, e}, {3'h0, rx});
  endtask : rd
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // ****************************************
  // scenarios
  // ****************************************
  task automatic testWrite;
    winBase = 3'h5;
    coreStopped = 1'b1;
    wakes = 0;
    writes = 0;
    i2c_master_model_i.start();
    tx(AW, 1'b0, "addr ack");
    coreStopped = 1'b0;
    tx(8'hFE, 1'b0, "ptr ack");
    chk("ptr no write", 11'h000, 11'(writes));
    chk("ptr load", 11'h0FE, {3'h0, ptrValue});
    tx(8'hA1, 1'b0, "data ack");
    chk("write in ack", 11'h001, 11'(writes));
    tx(8'hB2, 1'b0, "data ack");
    i2c_master_model_i.start();
    tx(AW, 1'b0, "addr ack");
    tx(8'hC3, 1'b0, "data ack");
    i2c_master_model_i.stop();
    chk("wake", 11'h001, 11'(wakes));
    chk("mem 5fe", 11'h0A1, {3'h0, mem[11'h5FE]});
    chk("mem 5ff", 11'h0B2, {3'h0, mem[11'h5FF]});
    chk("mem wrap", 11'h0C3, {3'h0, mem[11'h500]});
    chk("writes", 11'h003, 11'(writes));
    chk("ptr wrap", 11'h001, {3'h0, ptrValue});
  endtask : testWrite
  task automatic testEeprom;
    eepromMode = 1'b1;
    mem[11'h510] = 8'h3C;
    mem[11'h511] = 8'h5A;
    i2c_master_model_i.start();
    tx(AW, 1'b0, "addr ack");
    tx(8'h10, 1'b0, "ptr ack");
    reads = 0;
    i2c_master_model_i.start();
    tx(AR, 1'b0, "read addr ack");
    rd(1'b0, 8'h3C);
    rd(1'b1, 8'h5A);
    i2c_master_model_i.stop();
    repeat (50) @(negedge clk_sys);
    chk("eeprom fetches", 11'h002, 11'(reads));
    chk("eeprom ptr", 11'h012, {3'h0, ptrValue});
  endtask : testEeprom
  task automatic testAhead;
    eepromMode = 1'b0;
    for (int i = 0; i < 6; i++) mem[11'h520 + i] = 8'(8'h11 * (i + 1));
    i2c_master_model_i.start();
    tx(AW, 1'b0, "addr ack");
    tx(8'h20, 1'b0, "ptr ack");
    reads = 0;
    i2c_master_model_i.start();
    tx(AR, 1'b0, "read addr ack");
    rd(1'b1, 8'h11);
    i2c_master_model_i.stop();
    repeat (100) @(negedge clk_sys);
    chk("ahead fetches", 11'h003, 11'(reads));
    i2c_master_model_i.start();
    tx(AR, 1'b0, "read addr ack");
    rd(1'b0, 8'h22);
    rd(1'b1, 8'h33);
    i2c_master_model_i.stop();
    repeat (100) @(negedge clk_sys);
    chk("ahead fetches", 11'h005, 11'(reads));
    chk("ahead ptr", 11'h025, {3'h0, ptrValue});
    fifoFlush = 1'b1;
    @(negedge clk_sys);
    fifoFlush = 1'b0;
    i2c_master_model_i.start();
    tx(AR, 1'b0, "read addr ack");
    rd(1'b1, 8'h66);
    i2c_master_model_i.stop();
  endtask : testAhead
  task automatic testBusy;
    stretchDis = 1'b1;
    stretched = 1'b0;
    i2c_master_model_i.start();
    tx(AW, 1'b0, "addr ack");
    tx(8'h40, 1'b0, "ptr ack");
    writes = 0;
    devBusy = 1'b1;
    tx(8'h99, 1'b1, "data nack");
    i2c_master_model_i.stop();
    chk("nack no write", 11'h000, 11'(writes));
    i2c_master_model_i.start();
    tx(AW, 1'b1, "poll nack");
    i2c_master_model_i.start();
    tx(AW, 1'b1, "poll nack");
    devBusy = 1'b0;
    dmaEn = 1'b0;
    i2c_master_model_i.start();
    tx(AW, 1'b1, "dma off nack");
    dmaEn = 1'b1;
    i2c_master_model_i.start();
    tx(AW, 1'b0, "poll ack");
    i2c_master_model_i.stop();
    chk("no stretch", 11'h000, {10'h000, stretched});
  endtask : testBusy
  task automatic testStretch;
    stretchDis = 1'b0;
    devBusy = 1'b1;
    stretched = 1'b0;
    fork
      begin
        i2c_master_model_i.start();
        tx(AW, 1'b0, "stretched ack");
      end
      begin
        repeat (800) @(negedge clk_sys);
        devBusy = 1'b0;
      end
    join
    i2c_master_model_i.stop();
    chk("scl held", 11'h001, {10'h000, stretched});
  endtask : testStretch
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_b, eepromMode, stretchDis, devBusy, coreStopped, fifoFlush} = '0;
    {stretched, winBase} = '0;
    dmaEn = 1'b1;
    miscompares = 0;
    tests_run = 0;
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (10) @(negedge clk_sys);
    testWrite();
    testEeprom();
    testAhead();
    testBusy();
    testStretch();
    results();
  end
  // whole run needs about 9000 cycles
  initial begin
    repeat (80000) @(posedge clk_sys);
    miscompares++;
    results();
  end
endmodule : i2c_slave_sram_dma_tb_top
`default_nettype wire
